// *** mbtg_fifo.sv ***
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/10ps
module mbtg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_b_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + (AW+1)'(1);
        end else if (pop && !push) begin
            next_count = count - (AW+1)'(1);
        end
    end

    // Ready and valid are flops so the ports never see a combinational path
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count       <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            count       <= next_count;
            in_ready_o  <= next_count != (AW+1)'(DEPTH);
            out_valid_o <= next_count != '0;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule : mbtg_fifo

// *** mbtg_transfer.sv ***
/*
 * Package and top module of the message buffer transfer engine: moves buffers
 * between the message RAM and the host staging buffers, and received frames
 * from the transient receive store into the message RAM.
 * Assumes message RAM and staging buffers outside, both with one cycle read
 * latency, and all inputs on core_clk_i.
 */
// Operation
// - Every transfer writes only inside the data section of the selected buffer.
// - A copy of a 127-length buffer into the read staging buffer leaves word 00h holding bytes 0 to 3.
// - A copy from the write staging buffer stops at the last data word, never touching the next RAM word.
// - A received frame lands correctly even when its data starts right after the last header word.
// - Host transfers on the last configured buffer are correct whatever their timing against receive moves.
// - RAM is a header partition then a data partition, the header end set by the last buffer index field.
`timescale 1ns/10ps
package mbtg_pkg;
    localparam int          DATA_W       = 32;
    localparam int          RAM_AW       = 11;
    localparam int          STG_AW       = 6;
    localparam int          FIFO_DEPTH   = 8;
    localparam logic [11:0] RAM_WORDS    = 12'h800;
    localparam logic [1:0]  HDR_LEN_OFS  = 2'h2;
    localparam logic [1:0]  HDR_PTR_OFS  = 2'h3;
    localparam logic [6:0]  PAYLOAD_MAX  = 7'h7f;

    typedef enum logic [3:0] {
        S_IDLE    = 4'h0,
        S_HDR_LEN = 4'h1,
        S_HDR_PTR = 4'h3,
        S_CHECK   = 4'h2,
        S_RD_ADDR = 4'h6,
        S_RD_DATA = 4'h7,
        S_WR_ADDR = 4'h5,
        S_WR_DATA = 4'h4,
        S_RX_WR   = 4'hc,
        S_DONE    = 4'hd
    } mbtg_state_t;
endpackage : mbtg_pkg

module mbtg_transfer import mbtg_pkg::*; (
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rst_b_i,
    // Configuration
    input  wire logic [6:0]        last_buffer_index_field_i,
    // Host transfer request
    input  wire logic              host_req_valid_i,
    input  wire logic              host_req_write_i,
    input  wire logic [6:0]        host_req_buf_i,
    output logic                   host_ack_o,
    // Transient receive store frame request and data
    input  wire logic              rx_req_valid_i,
    input  wire logic [6:0]        rx_req_buf_i,
    output logic                   rx_ack_o,
    input  wire logic              rx_data_valid_i,
    input  wire logic [DATA_W-1:0] rx_data_i,
    output logic                   rx_data_ready_o,
    // Completion
    output logic                   done_o,
    output logic                   err_o,
    // Message RAM
    output logic [RAM_AW-1:0]      ram_addr_o,
    output logic                   ram_we_o,
    output logic [DATA_W-1:0]      ram_wdata_o,
    input  wire logic [DATA_W-1:0] ram_rdata_i,
    // Host staging buffers
    output logic [STG_AW-1:0]      stg_addr_o,
    output logic                   stg_we_o,
    output logic [DATA_W-1:0]      stg_wdata_o,
    input  wire logic [DATA_W-1:0] stg_rdata_i
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    mbtg_state_t        state;
    logic [6:0]         sel_buf;
    logic               xfer_rx;
    logic               xfer_wr;
    logic               discard;
    logic [7:0]         words;
    logic [7:0]         cnt;
    logic [RAM_AW-1:0]  ptr;
    logic [RAM_AW-1:0]  hdr_end;
    logic [RAM_AW-1:0]  hdr_base;
    logic [RAM_AW-1:0]  new_ptr;
    logic [11:0]        ptr_top;
    logic               ptr_ok;
    logic               last_word;
    logic               fifo_valid;
    logic [DATA_W-1:0]  fifo_data;
    logic               fifo_ready;

    // Header end follows the last buffer index, four words per header
    assign hdr_end  = {({2'b00, last_buffer_index_field_i} + 9'h001), 2'b00};
    assign hdr_base = {2'b00, sel_buf, 2'b00};
    assign new_ptr  = ram_rdata_i[RAM_AW-1:0];
    assign ptr_top  = {1'b0, new_ptr} + {4'h0, words};
    // Data at exactly hdr_end is legal; the single engine means no race with it
    assign ptr_ok   = (new_ptr >= hdr_end) && (ptr_top <= RAM_WORDS)
                      && (sel_buf <= last_buffer_index_field_i);
    assign last_word  = (cnt + 8'h01) == words;
    assign fifo_ready = (state == S_RX_WR);

    mbtg_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk_i  (core_clk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (rx_data_valid_i),
        .in_data_i   (rx_data_i),
        .in_ready_o  (rx_data_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_ready)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // One engine serves both requesters, so receive and host moves never interleave
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state   <= S_IDLE;
            sel_buf <= 7'h00;
            xfer_rx <= 1'b0;
            xfer_wr <= 1'b0;
            discard <= 1'b0;
            words   <= 8'h00;
            cnt     <= 8'h00;
            ptr     <= '0;
        end else begin
            unique case (state)
                S_IDLE: begin
                    cnt <= 8'h00;
                    if (rx_req_valid_i) begin
                        sel_buf <= rx_req_buf_i;
                        xfer_rx <= 1'b1;
                        xfer_wr <= 1'b1;
                        state   <= S_HDR_LEN;
                    end else if (host_req_valid_i) begin
                        sel_buf <= host_req_buf_i;
                        xfer_rx <= 1'b0;
                        xfer_wr <= host_req_write_i;
                        state   <= S_HDR_LEN;
                    end
                end
                S_HDR_LEN: state <= S_HDR_PTR;
                S_HDR_PTR: begin
                    // Payload length counts 16-bit words; round up to 32-bit words
                    words <= ({1'b0, ram_rdata_i[6:0] & PAYLOAD_MAX} + 8'h01) >> 1;
                    state <= S_CHECK;
                end
                S_CHECK: begin
                    ptr     <= new_ptr;
                    discard <= !ptr_ok;
                    if (xfer_rx) begin
                        state <= (words == 8'h00) ? S_DONE : S_RX_WR;
                    end else if (!ptr_ok || words == 8'h00) begin
                        state <= S_DONE;
                    end else begin
                        state <= xfer_wr ? S_WR_ADDR : S_RD_ADDR;
                    end
                end
                S_RD_ADDR: state <= S_RD_DATA;
                S_RD_DATA: begin
                    cnt   <= cnt + 8'h01;
                    state <= last_word ? S_DONE : S_RD_ADDR;
                end
                S_WR_ADDR: state <= S_WR_DATA;
                S_WR_DATA: begin
                    cnt   <= cnt + 8'h01;
                    state <= last_word ? S_DONE : S_WR_ADDR;
                end
                S_RX_WR: begin
                    if (fifo_valid) begin
                        cnt   <= cnt + 8'h01;
                        state <= last_word ? S_DONE : S_RX_WR;
                    end
                end
                S_DONE: state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Handshakes and completion
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_ack_o <= 1'b0;
            rx_ack_o   <= 1'b0;
            done_o     <= 1'b0;
            err_o      <= 1'b0;
        end else begin
            rx_ack_o   <= (state == S_IDLE) && rx_req_valid_i;
            host_ack_o <= (state == S_IDLE) && !rx_req_valid_i && host_req_valid_i;
            done_o     <= (state == S_DONE);
            err_o      <= (state == S_CHECK) && !ptr_ok;
        end
    end

    // ------------------------------------------------------------
    // Message RAM port
    // ------------------------------------------------------------
    // A rejected receive frame is still drained from the FIFO, but nothing is written
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ram_addr_o  <= '0;
            ram_we_o    <= 1'b0;
            ram_wdata_o <= '0;
        end else begin
            ram_we_o <= 1'b0;
            unique case (state)
                S_IDLE:    ram_addr_o <= {2'b00, (rx_req_valid_i ? rx_req_buf_i : host_req_buf_i), HDR_LEN_OFS};
                S_HDR_LEN: ram_addr_o <= hdr_base | {9'h000, HDR_PTR_OFS};
                S_CHECK:   ram_addr_o <= new_ptr;
                S_RD_DATA: ram_addr_o <= ptr + RAM_AW'(cnt + 8'h01);
                S_WR_DATA: begin
                    ram_we_o    <= 1'b1;
                    ram_addr_o  <= ptr + RAM_AW'(cnt);
                    ram_wdata_o <= stg_rdata_i;
                end
                S_RX_WR: begin
                    ram_we_o    <= fifo_valid && !discard;
                    ram_addr_o  <= ptr + RAM_AW'(cnt);
                    ram_wdata_o <= fifo_data;
                end
                default: ram_addr_o <= ram_addr_o;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Staging buffer port
    // ------------------------------------------------------------
    // Staging write index is the word count itself, never wrapped, so word 00h is not written twice
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stg_addr_o  <= '0;
            stg_we_o    <= 1'b0;
            stg_wdata_o <= '0;
        end else begin
            stg_we_o <= 1'b0;
            unique case (state)
                S_CHECK:   stg_addr_o <= '0;
                S_RD_DATA: begin
                    stg_we_o    <= 1'b1;
                    stg_addr_o  <= STG_AW'(cnt);
                    stg_wdata_o <= ram_rdata_i;
                end
                S_WR_DATA: stg_addr_o <= STG_AW'(cnt + 8'h01);
                default:   stg_addr_o <= stg_addr_o;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic stg0_seen;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stg0_seen <= 1'b0;
        end else if (state == S_IDLE) begin
            stg0_seen <= 1'b0;
        end else if (stg_we_o && stg_addr_o == '0) begin
            stg0_seen <= 1'b1;
        end
    end

    a_write_in_section: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ram_we_o |-> (ram_addr_o >= ptr) && ({1'b0, ram_addr_o} < ({1'b0, ptr} + {4'h0, words})))
        else $error("RAM write outside selected data section");
    a_stage_word0_kept: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (stg0_seen && stg_we_o) |-> stg_addr_o != '0)
        else $error("Staging word 0 written twice in one copy");
    a_host_write_stop: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (state == S_WR_DATA && last_word) |=> ram_we_o ##1 (!ram_we_o && state == S_IDLE))
        else $error("Extra RAM write after last data word");
    a_rx_first_data: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        (state == S_CHECK && xfer_rx && new_ptr == hdr_end && ptr_top <= RAM_WORDS
         && sel_buf <= last_buffer_index_field_i && words != 8'h00) |=> (state == S_RX_WR && !discard))
        else $error("Frame at first data word refused");
    a_one_owner: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        !(host_ack_o && rx_ack_o) && !(stg_we_o && ram_we_o))
        else $error("Two transfers active together");
    a_header_guard: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        ram_we_o |-> ram_addr_o >= hdr_end)
        else $error("Data write into header partition");

    c_host_read: cover property (@(posedge core_clk_i) state == S_RD_DATA && last_word);
    c_host_write: cover property (@(posedge core_clk_i) state == S_WR_DATA && last_word);
    c_rx_move: cover property (@(posedge core_clk_i) state == S_RX_WR && last_word && fifo_valid);
    c_rx_fifo_full: cover property (@(posedge core_clk_i) !rx_data_ready_o);
endmodule : mbtg_transfer

// *** mbtg_mem_model.sv ***
/*
 * Message RAM and host staging buffer models that face the transfer engine.
 * Assumes registered addresses from the engine and one cycle read latency.
 */
`timescale 1ns/10ps
module mbtg_mem_model import mbtg_pkg::*; (
    // Clock
    input  wire logic              core_clk_i,
    // Message RAM
    input  wire logic [RAM_AW-1:0] ram_addr_i,
    input  wire logic              ram_we_i,
    input  wire logic [DATA_W-1:0] ram_wdata_i,
    output logic      [DATA_W-1:0] ram_rdata_o,
    // Staging buffers
    input  wire logic [STG_AW-1:0] stg_addr_i,
    input  wire logic              stg_we_i,
    input  wire logic [DATA_W-1:0] stg_wdata_i,
    output logic      [DATA_W-1:0] stg_rdata_o
);
    logic [DATA_W-1:0] ram  [2048];
    logic [DATA_W-1:0] wstg [64];
    logic [DATA_W-1:0] rstg [64];
    // Read-first, so a word read at its own write edge returns the old value
    always @(posedge core_clk_i) begin
        ram_rdata_o <= ram[ram_addr_i];
        if (ram_we_i) begin
            ram[ram_addr_i] <= ram_wdata_i;
        end
    end
    always @(posedge core_clk_i) begin
        stg_rdata_o <= wstg[stg_addr_i];
        if (stg_we_i) begin
            rstg[stg_addr_i] <= stg_wdata_i;
        end
    end
endmodule : mbtg_mem_model

// *** mbtg_transfer_tb.sv ***
/*
 * Self-checking bench of the transfer engine with RAM and staging models.
 * Assumes the engine and model sources are compiled first.
 */
`timescale 1ns/10ps
module mbtg_transfer_tb import mbtg_pkg::*;;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic              clk = 1'b0, rst_b = 1'b0, hv = 1'b0, hw = 1'b0, rv = 1'b0, dv = 1'b0;
    logic [6:0]        lbi = 7'h03, hb = 7'h00, rb = 7'h00;
    logic [DATA_W-1:0] rd = 32'h0, rwd, rrd, swd, srd;
    logic [RAM_AW-1:0] raddr;
    logic [STG_AW-1:0] saddr;
    logic              ha, ra, dr, dn, er, rwe, swe;
    int                failures = 0, num_checks = 0, wr = 0, sw = 0, errs = 0, k, w0, s0, e0;

    always #4 clk = ~clk;
    always @(posedge clk) begin
        wr   = wr + int'(rwe === 1'b1);
        sw   = sw + int'(swe === 1'b1);
        errs = errs + int'(er === 1'b1);
    end

    mbtg_transfer DUT (.core_clk_i(clk), .rst_b_i(rst_b), .last_buffer_index_field_i(lbi),
        .host_req_valid_i(hv), .host_req_write_i(hw), .host_req_buf_i(hb), .host_ack_o(ha),
        .rx_req_valid_i(rv), .rx_req_buf_i(rb), .rx_ack_o(ra), .rx_data_valid_i(dv),
        .rx_data_i(rd), .rx_data_ready_o(dr), .done_o(dn), .err_o(er), .ram_addr_o(raddr),
        .ram_we_o(rwe), .ram_wdata_o(rwd), .ram_rdata_i(rrd), .stg_addr_o(saddr),
        .stg_we_o(swe), .stg_wdata_o(swd), .stg_rdata_i(srd));
    mbtg_mem_model M (.core_clk_i(clk), .ram_addr_i(raddr), .ram_we_i(rwe), .ram_wdata_i(rwd),
        .ram_rdata_o(rrd), .stg_addr_i(saddr), .stg_we_i(swe), .stg_wdata_i(swd), .stg_rdata_o(srd));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task end_sim;
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task hdr(input int b, input int len, input int ptr);
        M.ram[4*b+2] = 32'(len);
        M.ram[4*b+3] = 32'(ptr);
    endtask : hdr

    // Holds the request until its ack, then waits for done under a bound
    task automatic req(input logic is_rx, input logic w, input logic [6:0] b);
        int n;
        @(negedge clk);
        if (is_rx) begin
            rv = 1'b1;
            rb = b;
        end else begin
            hv = 1'b1;
            hw = w;
            hb = b;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((is_rx ? ra : ha) !== 1'b1 && n < 400);
        check({31'h0, n < 400}, 32'h1);
        @(negedge clk);
        if (is_rx) begin
            rv = 1'b0;
            rb = ~b;
        end else begin
            hv = 1'b0;
            hw = ~w;
            hb = ~b;
        end
        n = 0;
        while (dn !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check({31'h0, n < 400}, 32'h1);
        @(negedge clk);
    endtask : req

    task push(input int total, input int limit);
        int n;
        n = 0;
        while (k < total && n < limit) begin
            @(negedge clk);
            dv = 1'b1;
            rd = 32'hc0de0000 + 32'(k);
            @(posedge clk);
            k = k + int'(dr === 1'b1);
            n++;
        end
        @(negedge clk);
        dv = 1'b0;
        rd = ~rd;
    endtask : push

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_read_max;
        @(negedge clk);
        hdr(3, 127, 16);
        for (int i = 0; i < 64; i++) begin
            M.ram[16+i] = 32'h0b000000 + 32'(i);
            M.rstg[i]   = 32'hdead0000;
        end
        s0 = sw;
        req(1'b0, 1'b0, 7'h03);
        check(32'(sw - s0), 32'h40);
        for (int i = 0; i < 64; i++) check(M.rstg[i], 32'h0b000000 + 32'(i));
    endtask : t_read_max

    task t_write_last;
        @(negedge clk);
        hdr(3, 3, 16);
        for (int i = 0; i < 3; i++) M.wstg[i] = 32'h1e000000 + 32'(i);
        M.ram[18] = 32'h5e5e5e5e;
        w0 = wr;
        req(1'b0, 1'b1, 7'h03);
        check(32'(wr - w0), 32'h2);
        for (int i = 0; i < 2; i++) check(M.ram[16+i], 32'h1e000000 + 32'(i));
        check(M.ram[18], 32'h5e5e5e5e);
    endtask : t_write_last

    // Receive move into the section right after the headers, host read racing it
    task t_rx_race;
        @(negedge clk);
        hdr(2, 32, 16);
        hdr(3, 4, 40);
        M.ram[40] = 32'h3a000000;
        M.ram[41] = 32'h3a000001;
        M.ram[32] = 32'h5e5e5e5e;
        k = 0;
        push(16, 12);
        check(32'(k), 32'(FIFO_DEPTH));
        w0 = wr;
        fork
            push(16, 400);
            req(1'b1, 1'b0, 7'h02);
            begin
                repeat (3) @(negedge clk);
                req(1'b0, 1'b0, 7'h03);
            end
        join
        check(32'(wr - w0), 32'h10);
        for (int i = 0; i < 16; i++) check(M.ram[16+i], 32'hc0de0000 + 32'(i));
        check(M.ram[32], 32'h5e5e5e5e);
        for (int i = 0; i < 2; i++) check(M.rstg[i], 32'h3a000000 + 32'(i));
    endtask : t_rx_race

    task t_reject;
        @(negedge clk);
        hdr(3, 2, 15);
        e0 = errs;
        w0 = wr;
        s0 = sw;
        req(1'b0, 1'b1, 7'h03);
        req(1'b0, 1'b0, 7'h03);
        req(1'b0, 1'b1, 7'h05);
        check(32'(errs - e0), 32'h3);
        check(32'(wr - w0 + sw - s0), 32'h0);
        hdr(1, 2, 17);
        M.wstg[0] = 32'h77000000;
        M.ram[16] = 32'h5e5e5e5e;
        req(1'b0, 1'b1, 7'h01);
        check(M.ram[17], 32'h77000000);
        check(M.ram[16], 32'h5e5e5e5e);
    endtask : t_reject

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 2048; i++) M.ram[i] = ~32'(i);
        repeat (10) @(negedge clk);
        check(32'({dr, ha, ra, dn, er, rwe, swe}), 32'h40);
        rst_b = 1'b1;
        t_read_max;
        t_write_last;
        t_rx_race;
        t_reject;
        end_sim;
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #32000;
        failures++;
        end_sim;
    end
endmodule : mbtg_transfer_tb
